/* rtl/tcmcr_avg.v */
// Sample averager: accumulates 1 to 1024 signed samples and shifts out the mean
`timescale 1ns/1ps
`default_nettype none
`include "tcmcr_map.vh"

module tcmcr_avg (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      clear,
  input  wire                      take,
  input  wire [2:0]                avg_sel,
  input  wire [`TCMCR_RES_W-1:0]   sample,
  output reg                       done_q,
  output reg  [`TCMCR_RES_W-1:0]   result_q
);

  localparam ACC_W = `TCMCR_RES_W + 10;

  reg  [ACC_W-1:0] acc_q;
  reg  [9:0]       cnt_q;
  wire [ACC_W-1:0] sample_ext;
  wire [ACC_W-1:0] acc_sum;
  wire [ACC_W-1:0] acc_mean;

  // Number of samples less one for each averaging code
  function [9:0] last_index;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: last_index = 10'h000;
        3'h1: last_index = 10'h003;
        3'h2: last_index = 10'h00f;
        3'h3: last_index = 10'h03f;
        3'h4: last_index = 10'h07f;
        3'h5: last_index = 10'h0ff;
        3'h6: last_index = 10'h1ff;
        default: last_index = 10'h3ff;
      endcase
    end
  endfunction

  // Divide shift for each averaging code
  function [3:0] mean_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: mean_shift = 4'h0;
        3'h1: mean_shift = 4'h2;
        3'h2: mean_shift = 4'h4;
        3'h3: mean_shift = 4'h6;
        3'h4: mean_shift = 4'h7;
        3'h5: mean_shift = 4'h8;
        3'h6: mean_shift = 4'h9;
        default: mean_shift = 4'ha;
      endcase
    end
  endfunction

  // Sign extension keeps negative readings in twos complement
  assign sample_ext = {{10{sample[`TCMCR_RES_W-1]}}, sample};
  assign acc_sum    = acc_q + sample_ext;
  assign acc_mean   = $signed(acc_sum) >>> mean_shift(avg_sel);

  // Accumulate until the selected count is reached
  always @(posedge clk) begin
    if (rst || clear) begin
      acc_q  <= {ACC_W{1'b0}};
      cnt_q  <= 10'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (take) begin
        if (cnt_q == last_index(avg_sel)) begin
          acc_q  <= {ACC_W{1'b0}};
          cnt_q  <= 10'h000;
          done_q <= 1'b1;
        end else begin
          acc_q <= acc_sum;
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end

  // Mean is captured on the last sample
  always @(posedge clk) begin
    if (rst) begin
      result_q <= {`TCMCR_RES_W{1'b0}};
    end else if (take && !clear && cnt_q == last_index(avg_sel)) begin
      result_q <= acc_mean[`TCMCR_RES_W-1:0];
    end
  end

endmodule // tcmcr_avg

`default_nettype wire

/* rtl/tcmcr_map.vh */
// Register map, field positions, reset values and timing constants of the monitor
`ifndef TCMCR_MAP_VH
`define TCMCR_MAP_VH

// Register addresses
`define TCMCR_ADDR_CONFIG    8'h00
`define TCMCR_ADDR_CH1_SHUNT 8'h01
`define TCMCR_ADDR_CH1_BUS   8'h02
`define TCMCR_ADDR_CH2_SHUNT 8'h03

// Reset values
`define TCMCR_CFG_RESET    16'h7127
`define TCMCR_RESULT_RESET 16'h0000

// Configuration field positions
`define TCMCR_BIT_SWRESET 15
`define TCMCR_BIT_CHANNEL_ONE_ENABLE   14
`define TCMCR_BIT_CHANNEL_TWO_ENABLE   13
`define TCMCR_BIT_CHANNEL_THREE_ENABLE   12
`define TCMCR_AVG_HI      11
`define TCMCR_AVG_LO      9
`define TCMCR_BCT_HI      8
`define TCMCR_BCT_LO      6
`define TCMCR_SCT_HI      5
`define TCMCR_SCT_LO      3
`define TCMCR_OP_HI       2
`define TCMCR_OP_LO       0

// Operating field decode: shunt, bus and continuous flags
`define TCMCR_OP_SHUNT_BIT 0
`define TCMCR_OP_BUS_BIT   1
`define TCMCR_OP_CONT_BIT  2

// Result layout: sign and twelve data bits above three zero bits
`define TCMCR_RES_HI   15
`define TCMCR_RES_LO   3
`define TCMCR_RES_W    13
`define TCMCR_RES_PAD  3'b000

// Result weights
`define TCMCR_SHUNT_LSB_UV 40
`define TCMCR_BUS_LSB_MV   8

// Conversion times in ns and the clock period in ns
`define TCMCR_CLK_NS 10
`define TCMCR_CT0_NS 140000
`define TCMCR_CT1_NS 204000
`define TCMCR_CT2_NS 332000
`define TCMCR_CT3_NS 588000
`define TCMCR_CT4_NS 1100000
`define TCMCR_CT5_NS 2116000
`define TCMCR_CT6_NS 4156000
`define TCMCR_CT7_NS 8244000

// Conversion times in clock cycles at the 10 ns clock, sized to the timer
`define TCMCR_CT0_CYC 20'd14000
`define TCMCR_CT1_CYC 20'd20400
`define TCMCR_CT2_CYC 20'd33200
`define TCMCR_CT3_CYC 20'd58800
`define TCMCR_CT4_CYC 20'd110000
`define TCMCR_CT5_CYC 20'd211600
`define TCMCR_CT6_CYC 20'd415600
`define TCMCR_CT7_CYC 20'd824400

// Width of the conversion timer
`define TCMCR_TMR_W 20

`endif

/* rtl/tcmcr_top.v */
// Configuration, conversion sequencing and result registers of the monitor
`timescale 1ns/1ps
`default_nettype none
`include "tcmcr_map.vh"

module tcmcr_top #(
  parameter [`TCMCR_TMR_W-1:0] CT0_CYC = `TCMCR_CT0_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT1_CYC = `TCMCR_CT1_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT2_CYC = `TCMCR_CT2_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT3_CYC = `TCMCR_CT3_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT4_CYC = `TCMCR_CT4_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT5_CYC = `TCMCR_CT5_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT6_CYC = `TCMCR_CT6_CYC,
  parameter [`TCMCR_TMR_W-1:0] CT7_CYC = `TCMCR_CT7_CYC
) (
  input  wire                      MCLK,
  input  wire                      RST,
  input  wire [7:0]                REG_ADDR,
  input  wire                      REG_WR,
  input  wire [15:0]               REG_WDATA,
  input  wire                      REG_RD,
  output reg  [15:0]               REG_RDATA,
  output reg                       REG_RVALID,
  input  wire [`TCMCR_RES_W-1:0]   ADC_CODE,
  output wire                      SAMPLE_TAKE,
  output wire                      MEAS_ACTIVE,
  output reg  [1:0]                MEAS_CHANNEL,
  output reg                       MEAS_BUS,
  output reg                       PASS_DONE
);

  // One-hot sequencer states
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_CONV   = 3'b010;
  localparam [2:0] ST_SETTLE = 3'b100;

  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg  [15:0]             cfg_q;
  reg                     sw_rst_q;
  reg                     restart_q;
  reg  [2:0]              step_q;
  reg  [2:0]              step_d;
  reg  [`TCMCR_TMR_W-1:0] tmr_q;
  reg  [`TCMCR_TMR_W-1:0] tmr_d;
  reg                     pass_d;
  reg  [15:0]             ch1_shunt_q;
  reg  [15:0]             ch1_bus_q;
  reg  [15:0]             ch2_shunt_q;
  reg  [3:0]              pick;
  reg  [15:0]             rdata_d;

  wire                    rst_int;
  wire                    cfg_wr;
  wire [5:0]              step_mask;
  wire [2:0]              op_sel;
  wire                    op_cont;
  wire                    tmr_end;
  wire                    avg_done;
  wire [`TCMCR_RES_W-1:0] avg_result;
  wire [15:0]             avg_word;

  // Cycles of a conversion for a time code
  function [`TCMCR_TMR_W-1:0] ct_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: ct_cycles = CT0_CYC;
        3'h1: ct_cycles = CT1_CYC;
        3'h2: ct_cycles = CT2_CYC;
        3'h3: ct_cycles = CT3_CYC;
        3'h4: ct_cycles = CT4_CYC;
        3'h5: ct_cycles = CT5_CYC;
        3'h6: ct_cycles = CT6_CYC;
        default: ct_cycles = CT7_CYC;
      endcase
    end
  endfunction

  // First enabled step at or after a start index; bit 3 flags a hit
  function [3:0] first_step;
    input [5:0] mask;
    input [2:0] start;
    integer i;
    reg     hit;
    begin
      hit        = 1'b0;
      first_step = 4'h0;
      for (i = 0; i < 6; i = i + 1) begin
        if (!hit && mask[i] && i >= start) begin
          hit        = 1'b1;
          first_step = {1'b1, i[2:0]};
        end
      end
    end
  endfunction

  // Timer reload for a step: odd steps are bus, even steps shunt
  function [`TCMCR_TMR_W-1:0] step_load;
    input [2:0]  step;
    input [15:0] cfg;
    begin
      if (step[0]) begin
        step_load = ct_cycles(cfg[`TCMCR_BCT_HI:`TCMCR_BCT_LO]) -
                    {{(`TCMCR_TMR_W-1){1'b0}}, 1'b1};
      end else begin
        step_load = ct_cycles(cfg[`TCMCR_SCT_HI:`TCMCR_SCT_LO]) -
                    {{(`TCMCR_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Software reset joins the pin reset for one cycle
  assign rst_int = RST | sw_rst_q;
  assign cfg_wr  = REG_WR && REG_ADDR == `TCMCR_ADDR_CONFIG;

  // Operating code decode; 000 and 100 leave no step selected
  assign op_sel  = cfg_q[`TCMCR_OP_HI:`TCMCR_OP_LO];
  assign op_cont = op_sel[`TCMCR_OP_CONT_BIT];

  // Steps per channel: shunt then bus, only for enabled channels
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mask
      assign step_mask[2*g]   = cfg_q[`TCMCR_BIT_CHANNEL_ONE_ENABLE-g] &
                                op_sel[`TCMCR_OP_SHUNT_BIT];
      assign step_mask[2*g+1] = cfg_q[`TCMCR_BIT_CHANNEL_ONE_ENABLE-g] &
                                op_sel[`TCMCR_OP_BUS_BIT];
    end
  endgenerate

  assign tmr_end     = state_q == ST_CONV && tmr_q == {`TCMCR_TMR_W{1'b0}};
  assign SAMPLE_TAKE = tmr_end && !restart_q;
  assign MEAS_ACTIVE = state_q != ST_IDLE;
  assign avg_word    = {avg_result, `TCMCR_RES_PAD};

  // Averager of the current step
  tcmcr_avg u_avg (
    .clk      (MCLK),
    .rst      (rst_int),
    .clear    (restart_q || state_q == ST_IDLE),
    .take     (SAMPLE_TAKE),
    .avg_sel  (cfg_q[`TCMCR_AVG_HI:`TCMCR_AVG_LO]),
    .sample   (ADC_CODE),
    .done_q   (avg_done),
    .result_q (avg_result)
  );

  // Soft reset pulse; the written word itself is dropped
  always @(posedge MCLK) begin
    if (RST) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= cfg_wr && REG_WDATA[`TCMCR_BIT_SWRESET] && !sw_rst_q;
    end
  end

  // Configuration word; bit 15 is never stored so it reads back 0
  always @(posedge MCLK) begin
    if (rst_int) begin
      cfg_q <= `TCMCR_CFG_RESET;
    end else if (cfg_wr && !REG_WDATA[`TCMCR_BIT_SWRESET]) begin
      cfg_q <= {1'b0, REG_WDATA[14:0]};
    end
  end

  // Restart request after reset or a settings write
  always @(posedge MCLK) begin
    if (rst_int) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= cfg_wr && !REG_WDATA[`TCMCR_BIT_SWRESET];
    end
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    step_d  = step_q;
    tmr_d   = tmr_q;
    pass_d  = 1'b0;
    pick    = 4'h0;
    if (restart_q) begin
      pick = first_step(step_mask, 3'h0);
      if (pick[3]) begin
        state_d = ST_CONV;
        step_d  = pick[2:0];
        tmr_d   = step_load(pick[2:0], cfg_q);
      end else begin
        state_d = ST_IDLE;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_CONV: begin
          if (tmr_end) begin
            state_d = ST_SETTLE;
          end else begin
            tmr_d = tmr_q - {{(`TCMCR_TMR_W-1){1'b0}}, 1'b1};
          end
        end
        ST_SETTLE: begin
          if (!avg_done) begin
            state_d = ST_CONV;
            tmr_d   = step_load(step_q, cfg_q);
          end else begin
            pick = first_step(step_mask, step_q + 3'h1);
            if (!pick[3]) begin
              pass_d = 1'b1;
              pick   = first_step(step_mask, 3'h0);
            end
            if (pick[3] && (!pass_d || op_cont)) begin
              state_d = ST_CONV;
              step_d  = pick[2:0];
              tmr_d   = step_load(pick[2:0], cfg_q);
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always @(posedge MCLK) begin
    if (rst_int) begin
      state_q <= ST_IDLE;
      step_q  <= 3'h0;
      tmr_q   <= {`TCMCR_TMR_W{1'b0}};
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      tmr_q   <= tmr_d;
    end
  end

  // Step status outputs
  always @(posedge MCLK) begin
    if (rst_int) begin
      MEAS_CHANNEL <= 2'h0;
      MEAS_BUS     <= 1'b0;
      PASS_DONE    <= 1'b0;
    end else begin
      MEAS_CHANNEL <= step_d[2:1];
      MEAS_BUS     <= step_d[0];
      PASS_DONE    <= pass_d;
    end
  end

  // Result registers load only from the averager; bus writes never reach them
  always @(posedge MCLK) begin
    if (rst_int) begin
      ch1_shunt_q <= `TCMCR_RESULT_RESET;
      ch1_bus_q   <= `TCMCR_RESULT_RESET;
      ch2_shunt_q <= `TCMCR_RESULT_RESET;
    end else if (state_q == ST_SETTLE && avg_done && !restart_q) begin
      case (step_q)
        3'h0: ch1_shunt_q <= avg_word;
        3'h1: ch1_bus_q   <= avg_word;
        3'h2: ch2_shunt_q <= avg_word;
        default: ch1_shunt_q <= ch1_shunt_q;
      endcase
    end
  end

  // Read mux; reads touch nothing but the data register
  always @* begin
    case (REG_ADDR)
      `TCMCR_ADDR_CONFIG:    rdata_d = cfg_q;
      `TCMCR_ADDR_CH1_SHUNT: rdata_d = ch1_shunt_q;
      `TCMCR_ADDR_CH1_BUS:   rdata_d = ch1_bus_q;
      `TCMCR_ADDR_CH2_SHUNT: rdata_d = ch2_shunt_q;
      default:               rdata_d = 16'h0000;
    endcase
  end

  // Registered read answer one cycle after the strobe
  always @(posedge MCLK) begin
    if (rst_int) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

endmodule // tcmcr_top

`default_nettype wire

/* test/tb.sv */
// Self-checking bench: host model, front-end stimulus and result model
`timescale 1ns/1ps
`default_nettype none
`include "tcmcr_map.vh"
module tb;
  logic        MCLK;
  logic        RST;
  logic [12:0] ADC_CODE;
  logic [7:0]  REG_ADDR;
  logic        REG_WR;
  logic [15:0] REG_WDATA;
  logic        REG_RD;
  logic [15:0] REG_RDATA;
  logic        REG_RVALID;
  logic        SAMPLE_TAKE;
  logic        MEAS_ACTIVE;
  logic [1:0]  MEAS_CHANNEL;
  logic        MEAS_BUS;
  logic        PASS_DONE;
  logic [15:0] exp_r [4];
  logic [15:0] cfg_m;
  logic [15:0] pend_v;
  logic [15:0] w;
  logic [2:0]  key_m;
  logic [2:0]  tc_m;
  logic        swr_m = 1'b0;
  int          err_total;
  int          checks_done;
  int          cyc;
  int          sum;
  int          cnt;
  int          last_t;
  int          pend_a;
  int          n_pass;
  int          sh [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  // Conversion cycles per time code: the three shortest keep their real length
  int          ct_cyc [8] = '{`TCMCR_CT0_CYC, `TCMCR_CT1_CYC, `TCMCR_CT2_CYC, 7, 8, 9, 10, 11};

  tcmcr_top #(.CT3_CYC(20'd7), .CT4_CYC(20'd8), .CT5_CYC(20'd9), .CT6_CYC(20'd10),
    .CT7_CYC(20'd11)) dut (
    .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .ADC_CODE(ADC_CODE),
    .SAMPLE_TAKE(SAMPLE_TAKE), .MEAS_ACTIVE(MEAS_ACTIVE), .MEAS_CHANNEL(MEAS_CHANNEL),
    .MEAS_BUS(MEAS_BUS), .PASS_DONE(PASS_DONE));
  tcmcr_host host (.clk(MCLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] e);
    checks_done++;
    if (got !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // Reads a register and checks both the answer strobe and the word
  task automatic regchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    host.rd(a, d, ok);
    cmp({15'h0, ok}, 16'h0001);
    cmp(d, e);
  endtask

  task automatic chk_rst;
    for (int a = 1; a < 4; a++) regchk(8'(a), 16'h0000);
    regchk(8'h00, 16'h7127);
  endtask

  // Clock at 100 MHz
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Front end: a fresh random signed code every cycle
  always @(negedge MCLK) ADC_CODE <= 13'($urandom);

  // Reference model: averages each step and loads its result one cycle later
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      conclude();
    end
    if (pend_a != 0) exp_r[pend_a] = pend_v;
    pend_a = 0;
    // A reset-bit write acts as a reset one cycle after its own edge
    if (RST || swr_m) begin
      exp_r = '{4{16'h0000}};
      cfg_m = 16'h7127;
      cnt = 0;
      last_t = cyc;
    end else if (REG_WR && REG_ADDR == 8'h00 && !REG_WDATA[15]) begin
      cfg_m = REG_WDATA;
      cnt = 0;
      last_t = cyc;
    end else if (SAMPLE_TAKE === 1'b1) begin
      // Every take follows the last take or restart by its time code plus one settle or restart cycle
      tc_m = MEAS_BUS ? cfg_m[8:6] : cfg_m[5:3];
      cmp(16'(cyc - last_t), 16'(ct_cyc[tc_m] + 1));
      if (cnt == 0 || key_m != {MEAS_CHANNEL, MEAS_BUS}) begin
        sum = 0;
        cnt = 0;
      end
      key_m = {MEAS_CHANNEL, MEAS_BUS};
      last_t = cyc;
      sum += $signed(ADC_CODE);
      cnt++;
      if (cnt == (1 << sh[cfg_m[11:9]])) begin
        pend_v = {13'(sum >>> sh[cfg_m[11:9]]), 3'h0};
        pend_a = (key_m == 3'h0) ? 1 : (key_m == 3'h1) ? 2 : (key_m == 3'h2) ? 3 : 0;
        cnt = 0;
      end
    end
    swr_m = !RST && !swr_m && REG_WR && REG_ADDR == 8'h00 && REG_WDATA[15];
  end

  // Main sequence
  initial begin
    RST = 1'b1;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    cnt = 0;
    pend_a = 0;
    void'($urandom(43));
    repeat (8) @(posedge MCLK);
    @(negedge MCLK);
    RST = 1'b0;
    chk_rst();
    // Both power-down codes leave the sequencer idle
    for (int m = 0; m < 8; m += 4) begin
      host.wr(8'h00, 16'h7120 | 16'(m));
      repeat (20) @(negedge MCLK);
      cmp({15'h0, MEAS_ACTIVE}, 16'h0000);
    end
    // Single-shot passes over every averaging and trigger code and every time code except 2
    // The last pass runs the short real codes, shunt 0 and bus 1, on channel 1 alone
    for (int k = 0; k < 9; k++) begin
      w = {2'b01, 2'($urandom), 3'(k), 3'(k < 5 ? 7 - k : 3), 3'(k < 5 ? 7 - k : 3),
           3'(k % 3 + 1)};
      if (k == 8) w = 16'h4043;
      host.wr(8'h00, w);
      while (PASS_DONE !== 1'b1) @(negedge MCLK);
      repeat (8) @(negedge MCLK);
      cmp({15'h0, MEAS_ACTIVE}, 16'h0000);
      for (int a = 1; a < 4; a++) regchk(8'(a), exp_r[a]);
      regchk(8'h00, w);
    end
    // Writes to a result and to an unmapped place change nothing
    host.wr(8'h02, 16'($urandom));
    host.wr(8'h7f, 16'($urandom));
    regchk(8'h02, exp_r[2]);
    regchk(8'h7f, 16'h0000);
    // Continuous modes keep looping; each write restarts the sequence
    for (int m = 5; m < 8; m++) begin
      host.wr(8'h00, 16'h70d8 | 16'(m));
      n_pass = 0;
      repeat (200) begin
        @(negedge MCLK);
        n_pass += PASS_DONE;
      end
      cmp(16'(n_pass > 2), 16'h0001);
    end
    host.wr(8'h00, 16'h8000 | 16'($urandom));
    chk_rst();
    conclude();
  end
endmodule // tb
`default_nettype wire

/* test/tcmcr_chk_sva.sv */
// Checker for the register port and conversion sequencing of the monitor
`timescale 1ns/1ps
`default_nettype none
module tcmcr_chk (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic        SAMPLE_TAKE,
  input wire logic        MEAS_ACTIVE,
  input wire logic [1:0]  MEAS_CHANNEL,
  input wire logic        MEAS_BUS,
  input wire logic        PASS_DONE
);
  logic [15:0] cfg_q;
  logic [2:0]  age_q;
  logic        rd_q;
  logic [7:0]  adr_q;

  // Shadow of the configuration word and cycles since it last changed
  always_ff @(posedge MCLK) begin
    rd_q <= REG_RD && !RST;
    adr_q <= REG_ADDR;
    if (RST || (REG_WR && REG_ADDR == 8'h00 && REG_WDATA[15])) begin
      cfg_q <= 16'h7127;
      age_q <= 3'h0;
    end else if (REG_WR && REG_ADDR == 8'h00) begin
      cfg_q <= REG_WDATA;
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_read_answer: assert property (REG_RVALID == rd_q)
    else $error("read answer out of step with request");
  a_cfg_sign: assert property (REG_RVALID && adr_q == 8'h00 |-> !REG_RDATA[15])
    else $error("configuration reads back bit 15 set");
  a_result_pad: assert property (REG_RVALID && adr_q != 8'h00 |-> REG_RDATA[2:0] == 3'h0)
    else $error("result low bits not zero");
  a_take_gap: assert property (SAMPLE_TAKE |=> !SAMPLE_TAKE [*3])
    else $error("samples taken too close together");
  a_take_active: assert property (SAMPLE_TAKE |-> MEAS_ACTIVE)
    else $error("sample taken while idle");
  a_pd_idle: assert property (age_q == 3'h7 && cfg_q[1:0] == 2'h0 |-> !MEAS_ACTIVE)
    else $error("converting in power-down");
  a_shunt_only: assert property (age_q == 3'h7 && MEAS_ACTIVE && !cfg_q[1] |-> !MEAS_BUS)
    else $error("bus step in a shunt-only mode");
  a_bus_only: assert property (age_q == 3'h7 && MEAS_ACTIVE && !cfg_q[0] |-> MEAS_BUS)
    else $error("shunt step in a bus-only mode");
  a_chan_skip: assert property (age_q == 3'h7 && MEAS_ACTIVE |-> cfg_q[14 - MEAS_CHANNEL])
    else $error("disabled channel converted");
  a_single_stop: assert property (PASS_DONE && !cfg_q[2] |-> ##[1:3] !MEAS_ACTIVE)
    else $error("single-shot pass did not stop");
  a_cont_loop: assert property (PASS_DONE && cfg_q[2] && age_q == 3'h7 |-> ##[1:3] MEAS_ACTIVE)
    else $error("continuous mode stopped after a pass");
endmodule // tcmcr_chk

bind tcmcr_top tcmcr_chk u_chk (
  .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .SAMPLE_TAKE(SAMPLE_TAKE), .MEAS_ACTIVE(MEAS_ACTIVE),
  .MEAS_CHANNEL(MEAS_CHANNEL), .MEAS_BUS(MEAS_BUS), .PASS_DONE(PASS_DONE)
);
`default_nettype wire

/* test/tcmcr_host.sv */
// Register host model driving the strobe port of the monitor
`timescale 1ns/1ps
`default_nettype none
module tcmcr_host (
  input  wire logic        clk,
  output var  logic [7:0]  REG_ADDR,
  output var  logic        REG_WR,
  output var  logic [15:0] REG_WDATA,
  output var  logic        REG_RD,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_RVALID
);
  // Idle port at time zero
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_WDATA = 16'h0000;
    REG_RD = 1'b0;
  end

  // One write strobe; released data shows its inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge clk);
    REG_WR = 1'b0;
    REG_WDATA = ~d;
  endtask

  // One read strobe; the answer stands in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge clk);
    REG_RD = 1'b0;
    ok = REG_RVALID;
    d = REG_RDATA;
  endtask
endmodule // tcmcr_host
`default_nettype wire
